// >>> hdl/kwdt_defs.vh
// register offsets, reset values, keys and timing counts of the keyed watchdog
`ifndef KWDT_DEFS_VH
`define KWDT_DEFS_VH

`define KWDT_OFS_MODE        4'h0
`define KWDT_OFS_CLOCK       4'h4
`define KWDT_OFS_RESTART     4'h8
`define KWDT_OFS_STATUS      4'hC

`define KWDT_MODE_KEY        12'h234
`define KWDT_CLOCK_KEY       9'h06E
`define KWDT_RESTART_KEY     16'hC071

`define KWDT_MODE_RESET      4'h0
`define KWDT_HPN_RESET       4'h0
`define KWDT_CKS_RESET       2'h0

`define KWDT_LOW_PRELOAD     12'hFFF
`define KWDT_PIN_CYCLES      4'h8

`define KWDT_DIV8_LAST       10'h007
`define KWDT_DIV32_LAST      10'h01F
`define KWDT_DIV128_LAST     10'h07F
`define KWDT_DIV1024_LAST    10'h3FF

`endif

// >>> hdl/kwdt_prescaler.v
// prescaler that yields one-cycle count ticks at the selected division of the master clock
`timescale 1ns/100ps
`default_nettype none
`include "kwdt_defs.vh"

module kwdt_prescaler (
    input  wire       mclk,
    input  wire       srst,
    input  wire       clk_en,
    input  wire       restart,
    input  wire [1:0] count_clock_select,
    output reg        tick_q
);

    reg [9:0] div_q;

    function [9:0] kwdt_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    kwdt_last = `KWDT_DIV8_LAST;
                2'h1:    kwdt_last = `KWDT_DIV32_LAST;
                2'h2:    kwdt_last = `KWDT_DIV128_LAST;
                default: kwdt_last = `KWDT_DIV1024_LAST;
            endcase
        end
    endfunction

    // restart also realigns the divider so the first period after a restart is whole
    always @(posedge mclk) begin
        if (srst) begin
            div_q  <= 10'h000;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            if (restart || div_q >= kwdt_last(count_clock_select)) begin
                div_q  <= 10'h000;
                tick_q <= ~restart;
            end else begin
                div_q  <= div_q + 10'h001;
                tick_q <= 1'b0;
            end
        end
    end

endmodule // kwdt_prescaler
`default_nettype wire

// >>> hdl/kwdt_top.v
// keyed watchdog timer with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
`include "kwdt_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - overflow with reset enable set raises the internal reset output
// - overflow with interrupt enable set gives an interrupt request pulse
// - overflow with pin enable set drives the low-active pin low eight cycles
// - the timing element is a sixteen-bit down counter
// - restart loads ones in bits 0-11 and the high preload nibble above
// - clock select divides master clock by 8, 32, 128 or 1024
// - mode and clock updates need the right key in the same write
// - overflow mode writes need key 0x234 in bits 15:4; key reads zero
// - clock mode writes need key 0x06E in bits 15:7; key reads zero
// - with the enable bit clear no output fires; set lets enabled outputs fire
// - writing 0xC071 to the restart register restarts; other values do nothing
// - overflow flag sets on overflow, stays until restart or system reset
// - after system reset the watchdog is disabled
module kwdt_top (
    input  wire        mclk,
    input  wire        srst,
    input  wire        clk_en,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         dog_internal_reset,
    output reg         dog_irq_pulse,
    output reg         overflow_pin_n
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg        dog_enable_q;
    reg        overflow_reset_enable_q;
    reg        overflow_irq_enable_q;
    reg        overflow_pin_enable_q;
    reg [3:0]  high_preload_nibble_q;
    reg [1:0]  count_clock_select_q;
    reg        overflow_flag_q;
    reg [15:0] count_q;
    reg        expired_q;
    reg [3:0]  pin_cnt_q;
    reg        ack_q;

    wire       tick;
    wire       req;
    wire       wr_now;
    wire       rd_now;
    wire       mode_wr;
    wire       clock_wr;
    wire       restart;
    wire       overflow;
    wire       fire;
    reg [31:0] rdata_d;

    // one wait cycle: request is answered on the second edge it is seen
    assign req    = avs_read | avs_write;
    assign wr_now = avs_write & ack_q;
    assign rd_now = avs_read & ack_q;

    // a partial write cannot carry a whole key, so the low two lanes must be enabled
    assign mode_wr  = wr_now && avs_address == `KWDT_OFS_MODE && (&avs_byteenable[1:0])
                      && avs_writedata[15:4] == `KWDT_MODE_KEY;
    assign clock_wr = wr_now && avs_address == `KWDT_OFS_CLOCK && (&avs_byteenable[1:0])
                      && avs_writedata[15:7] == `KWDT_CLOCK_KEY;
    assign restart  = wr_now && avs_address == `KWDT_OFS_RESTART && (&avs_byteenable[1:0])
                      && avs_writedata[15:0] == `KWDT_RESTART_KEY;

    // overflow fires once on the tick that takes the counter to zero
    assign overflow = tick && !expired_q && count_q == 16'h0001;
    assign fire     = overflow && dog_enable_q;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler

    kwdt_prescaler u_pre (
        .mclk               (mclk),
        .srst               (srst),
        .clk_en             (clk_en),
        .restart            (restart),
        .count_clock_select (count_clock_select_q),
        .tick_q             (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave

    always @* begin
        rdata_d = 32'h00000000;
        case (avs_address)
            `KWDT_OFS_MODE: begin
                rdata_d[3:0] = {overflow_pin_enable_q, overflow_irq_enable_q,
                                overflow_reset_enable_q, dog_enable_q};
            end
            `KWDT_OFS_CLOCK: begin
                rdata_d[5:0] = {high_preload_nibble_q, count_clock_select_q};
            end
            `KWDT_OFS_STATUS: begin
                rdata_d[0] = overflow_flag_q;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (clk_en) begin
            ack_q           <= req & ~ack_q;
            avs_waitrequest <= ~(req & ~ack_q);
            if (req && !ack_q && avs_read) begin
                avs_readdata <= rdata_d;
            end else if (rd_now) begin
                avs_readdata <= avs_readdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode and clock registers

    always @(posedge mclk) begin
        if (srst) begin
            {overflow_pin_enable_q, overflow_irq_enable_q,
             overflow_reset_enable_q, dog_enable_q} <= `KWDT_MODE_RESET;
            high_preload_nibble_q <= `KWDT_HPN_RESET;
            count_clock_select_q  <= `KWDT_CKS_RESET;
        end else if (clk_en) begin
            if (mode_wr) begin
                {overflow_pin_enable_q, overflow_irq_enable_q,
                 overflow_reset_enable_q, dog_enable_q} <= avs_writedata[3:0];
            end
            if (clock_wr) begin
                high_preload_nibble_q <= avs_writedata[5:2];
                count_clock_select_q  <= avs_writedata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter, flag and outputs

    always @(posedge mclk) begin
        if (srst) begin
            count_q            <= {`KWDT_HPN_RESET, `KWDT_LOW_PRELOAD};
            expired_q          <= 1'b0;
            overflow_flag_q    <= 1'b0;
            dog_internal_reset <= 1'b0;
            dog_irq_pulse      <= 1'b0;
            overflow_pin_n     <= 1'b1;
            pin_cnt_q          <= 4'h0;
        end else if (clk_en) begin
            if (restart) begin
                count_q   <= {high_preload_nibble_q, `KWDT_LOW_PRELOAD};
                expired_q <= 1'b0;
            end else if (tick && !expired_q) begin
                count_q   <= count_q - 16'h0001;
                expired_q <= count_q == 16'h0001;
            end
            // a restart in the overflow cycle loses: the overflow is still recorded
            if (overflow) begin
                overflow_flag_q <= 1'b1;
            end else if (restart) begin
                overflow_flag_q <= 1'b0;
            end
            // internal reset is one cycle; the reset controller stretches it
            dog_internal_reset <= fire && overflow_reset_enable_q;
            dog_irq_pulse      <= fire && overflow_irq_enable_q;
            if (fire && overflow_pin_enable_q) begin
                pin_cnt_q      <= `KWDT_PIN_CYCLES;
                overflow_pin_n <= 1'b0;
            end else if (pin_cnt_q > 4'h1) begin
                pin_cnt_q      <= pin_cnt_q - 4'h1;
                overflow_pin_n <= 1'b0;
            end else begin
                pin_cnt_q      <= 4'h0;
                overflow_pin_n <= 1'b1;
            end
        end
    end

endmodule // kwdt_top
`default_nettype wire

// >>> verif/kwdt_properties.sv
// port assertions for the keyed watchdog
`timescale 1ns/100ps
`default_nettype none
module kwdt_properties (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        clk_en,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        dog_internal_reset,
    input wire logic        dog_irq_pulse,
    input wire logic        overflow_pin_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_mode_key_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[31:4] == 28'h0)
        else $error("mode key field not read as zero");
    chk_clock_key_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4 |-> avs_readdata[31:6] == 26'h0)
        else $error("clock key field not read as zero");
    chk_irq_once: assert property (dog_irq_pulse |=> !dog_irq_pulse [*8])
        else $error("interrupt pulse longer than one cycle or repeated");
    chk_reset_once: assert property (dog_internal_reset |=> !dog_internal_reset [*8])
        else $error("internal reset pulse longer than one cycle");
    chk_pin_eight: assert property ($fell(overflow_pin_n) |-> !overflow_pin_n [*8] ##1 overflow_pin_n)
        else $error("overflow pin not low for eight cycles");
    chk_pin_rearm: assert property ($rose(overflow_pin_n) |-> overflow_pin_n [*8])
        else $error("overflow pin pulsed again at once");
    chk_quiet_reset: assert property ($fell(srst) |-> (overflow_pin_n && !dog_irq_pulse && !dog_internal_reset) [*8])
        else $error("watchdog output active after reset");
    cov_irq: cover property (dog_irq_pulse);
    cov_reset: cover property (dog_internal_reset);
    cov_pin: cover property ($fell(overflow_pin_n));
endmodule // kwdt_properties
bind kwdt_top kwdt_properties u_props (.mclk, .srst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .dog_internal_reset, .dog_irq_pulse, .overflow_pin_n);
`default_nettype wire

// >>> verif/test_keyed_watchdog_timer.sv
// register and overflow tests for the keyed watchdog
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    fail_count++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_keyed_watchdog_timer;
    logic        mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, clk_en = 1'b1;
    logic [3:0]  avs_address = 4'h0, ben = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
    logic        avs_waitrequest, dog_internal_reset, dog_irq_pulse, overflow_pin_n;
    int          fail_count = 0, comparisons = 0, cyc = 0, n, m, act, i;
    kwdt_top DUT (.mclk(mclk), .srst(srst), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(ben), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dog_internal_reset(dog_internal_reset),
        .dog_irq_pulse(dog_irq_pulse), .overflow_pin_n(overflow_pin_n));
    initial begin
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic stop_test;
        if (fail_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a hang in any wait below ends here instead of running forever
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fail_count++;
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            rd((i == 4) ? 4'h2 : 4'(i * 4));
            `CHECK("reset_read", 32'h0, rdv)
        end
        wr(4'h0, 32'h0000123F);
        rd(4'h0); `CHECK("mode_bad_key", 32'h0, rdv)
        wr(4'h0, 32'h0000234F);
        rd(4'h0); `CHECK("mode_good_key", 32'h0000000F, rdv)
        // a keyed write with only the low lane enabled cannot carry the whole key
        ben <= 4'h1;
        wr(4'h0, 32'h00002340);
        ben <= 4'hF;
        rd(4'h0); `CHECK("mode_part_lanes", 32'h0000000F, rdv)
        wr(4'h4, 32'h0000003F);
        rd(4'h4); `CHECK("clock_bad_key", 32'h0, rdv)
        wr(4'h4, 32'h0000373C);
        rd(4'h4); `CHECK("clock_good_key", 32'h0000003C, rdv)
        for (i = 3; i >= 0; i--) begin
            wr(4'h4, 32'h00003700 | i);
            rd(4'h4); `CHECK("clock_select", 32'(i), rdv)
        end
        // nibble 0 and divide by 8: overflow after 0xFFF ticks of 8 cycles, plus 100 frozen cycles
        wr(4'h8, 32'h0000C071);
        n = 0;
        // clock enable low holds counter and prescaler, so the overflow comes 100 cycles later
        clk_en <= 1'b0;
        repeat (100) begin @(posedge mclk); n++; end
        clk_en <= 1'b1;
        do begin @(posedge mclk); n++; end while (dog_irq_pulse !== 1'b1 && n < 40000);
        `CHECK("overflow_time", 1'b1, n >= 32860 && n <= 32876)
        `CHECK("internal_reset", 1'b1, dog_internal_reset)
        m = 0;
        while (overflow_pin_n === 1'b0 && m < 20) begin @(posedge mclk); m++; end
        `CHECK("pin_low_cycles", 8, m)
        wr(4'h8, 32'h0000C070);
        rd(4'hC); `CHECK("status_set", 32'h1, rdv)
        wr(4'h8, 32'h0000C071);
        rd(4'hC); `CHECK("status_cleared", 32'h0, rdv)
        // all outputs enabled but the master enable clear
        wr(4'h0, 32'h0000234E);
        wr(4'h8, 32'h0000C071);
        act = 0;
        repeat (32800) begin
            @(posedge mclk);
            if (dog_irq_pulse !== 1'b0 || dog_internal_reset !== 1'b0 || overflow_pin_n !== 1'b1) act++;
        end
        `CHECK("disabled_quiet", 0, act)
        rd(4'hC); `CHECK("disabled_flag", 32'h1, rdv)
        // a system reset in mid-run clears the mode bits and the overflow flag
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(4'h0); `CHECK("rerun_mode", 32'h0, rdv)
        rd(4'hC); `CHECK("rerun_flag", 32'h0, rdv)
        stop_test;
    end
endmodule // test_keyed_watchdog_timer
`default_nettype wire
